// file: rtl/bsc_pkg.sv
// Package: constants for the boundary-scan cell block
package bsc_pkg;
  // Synchroniser lanes
  localparam int SY_TCK   = 0;
  localparam int SY_TDI   = 1;
  localparam int SY_CAP   = 2;
  localparam int SY_SHIFT = 3;
  localparam int SY_UPD   = 4;
  localparam int SY_EXT   = 5;
  localparam int SY_RSEL  = 6;
  localparam int SY_RSTN  = 7;
  localparam int SY_HIGHVOLT_RESET_OBSERVE = 8;
  localparam int SY_CLK   = 9;
  localparam int SY_ACO   = 12;
  localparam int SY_COMP  = 13;
  localparam int SY_W     = 14;
  // Chain layout
  localparam int NPINS_DEF = 8;
  localparam int PIN_W     = 3;
  localparam int CELL_PU   = 0;
  localparam int CELL_OC   = 1;
  localparam int CELL_OD   = 2;
  localparam int M_RSTN    = 0;
  localparam int M_HIGHVOLT_RESET_OBSERVE   = 1;
  localparam int M_CLKEN   = 2;
  localparam int M_CLKOBS  = 5;
  localparam int M_ACIDLE  = 8;
  localparam int M_ACO     = 9;
  localparam int M_ACMUX   = 10;
  localparam int M_COMPARATOR_BANDGAP_ENABLE    = 11;
  localparam int M_COMP    = 12;
  localparam int M_ADC     = 13;
  localparam int MISC_W    = 42;
  localparam logic [12:0] MISC_RST = 13'h0100;
  // Clock cells: bit 0 external, 1 crystal, 2 low-frequency
  localparam logic [2:0] CLK_UNUSED = 3'h6;
  // ADC interface cells
  localparam int ADC_W      = 29;
  localparam int ADC_EN_BIT = 26;
  localparam logic [28:0] ADC_REC = 29'h2801E00;
  // Comparator control: bit 0 idle, 1 mux select, 2 bandgap
  localparam int COMPARATOR_IDLE_BIT = 0;
  // Timing
  localparam int CLK_NS       = 20;
  localparam int ADC_WARM_NS  = 200;
  localparam int ADC_WARM_CYC = (ADC_WARM_NS + CLK_NS - 1) / CLK_NS;
  // Registers
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam int CTRL_PUD  = 0;
  localparam int STAT_FLAG = 0;
endpackage

// file: rtl/bsc_sync_if.sv
// Interface: raw inputs to synchroniser and clean levels back
`timescale 1ns/10ps
interface bsc_sync_if #(parameter int W = 14);
  logic [W-1:0] raw;
  logic [W-1:0] lvl;
  logic         tckRise;
  modport syncer (input raw, output lvl, output tckRise);
  modport user (output raw, input lvl, input tckRise);
endinterface

// file: rtl/bsc_sync.sv
// Module: three-stage input synchroniser with test clock edge finder
`timescale 1ns/10ps
module bsc_sync
  import bsc_pkg::*;
#(
  parameter int W = SY_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Lanes
  bsc_sync_if.syncer sy
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic         rise;
  } bsc_sync_s;

  bsc_sync_s state_reg;
  bsc_sync_s state_next;

  always_comb begin
    state_next    = state_reg;
    state_next.s1 = sy.raw;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    // A change counts once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (state_reg.s2[i] == state_reg.s3[i]) begin
        state_next.lvl[i] = state_reg.s3[i];
      end
    end
    state_next.rise = (state_reg.s2[SY_TCK] == state_reg.s3[SY_TCK]) & state_reg.s3[SY_TCK]
                      & ~state_reg.lvl[SY_TCK];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sy.lvl     = state_reg.lvl;
  assign sy.tckRise = state_reg.rise;
endmodule

// file: rtl/bsc_cells.sv
// Module: boundary-scan data cells, reset register and test-reset flag
//
// Summary of operation
// - Test reset sets flag; power-on or zero-write clears
// - Pin has pull-up cell plus two-stage pin cell
// - Input unsynchronised; data to port, control to direction
// - Pull-up equals not-disable, not-direction, port bit
// - Alternate digital functions sit outside scanned cells
// - Analog cells sit on digital-analog interface signals
// - Reset pin has normal and high-voltage observe cells
// - Oscillator enable general cell, clock observe-only
// - Internal RC oscillator output is not scanned
// - Unused clock reads 0 external, 1 crystals
// - Idle comparator off, output reads zero
// - Hold low samples, high holds analog input
// - Comparator latch precharge is active low
// - ADC warm-up of 200 ns before use
// - Shift registers move least significant bit first
`timescale 1ns/10ps
module bsc_cells
  import bsc_pkg::*;
#(
  parameter int NPINS = NPINS_DEF
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Test port
  input  wire logic             tck,
  input  wire logic             tdi,
  input  wire logic             tapCapture,
  input  wire logic             tapShift,
  input  wire logic             tapUpdate,
  input  wire logic             tapExtest,
  input  wire logic             tapResetSel,
  output logic                  tdo,
  // Register port
  input  wire logic [3:0]       regAddr,
  input  wire logic [7:0]       regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic      [7:0]       regRdata,
  // Port pins
  input  wire logic [NPINS-1:0] portReg,
  input  wire logic [NPINS-1:0] dirReg,
  input  wire logic [NPINS-1:0] altEn,
  input  wire logic [NPINS-1:0] altOut,
  input  wire logic [NPINS-1:0] padIn,
  output logic      [NPINS-1:0] padOut,
  output logic      [NPINS-1:0] padOe_n,
  output logic      [NPINS-1:0] pinPullup,
  // Reset pin
  input  wire logic             rstPinLevel,
  input  wire logic             rstHvLevel,
  output logic                  coreReset,
  // Clock sources
  input  wire logic [2:0]       coreClkEn,
  input  wire logic [2:0]       clkLine,
  output logic      [2:0]       oscEnable,
  // Analog comparator
  input  wire logic [2:0]       coreAcCtl,
  input  wire logic             acOutIn,
  output logic      [2:0]       acCtl,
  // ADC
  input  wire logic [ADC_W-1:0] coreAdcCtl,
  input  wire logic             compIn,
  output logic      [ADC_W-1:0] adcCtl,
  output logic                  adcReady
);
  localparam int B  = PIN_W * NPINS;
  localparam int CW = B + MISC_W;
  localparam logic [CW-1:0] UP_RST = {ADC_REC, MISC_RST, {B{1'b0}}};

  typedef struct packed {
    logic [CW-1:0]    sh;
    logic [CW-1:0]    up;
    logic             rr;
    logic             tdo;
    logic             flag;
    logic             global_pullup_disable;
    logic             coreRst;
    logic [NPINS-1:0] padOut;
    logic [NPINS-1:0] padOe_n;
    logic [NPINS-1:0] pull;
    logic [2:0]       oscEn;
    logic [2:0]       acCtl;
    logic [ADC_W-1:0] adcCtl;
    logic [3:0]       warm;
    logic             adcReady;
    logic [7:0]       rdata;
  } bsc_cells_s;

  bsc_cells_s state_reg;
  bsc_cells_s state_next;

  bsc_sync_if #(.W(SY_W)) syIf ();

  assign syIf.raw = {compIn, acOutIn, clkLine, rstHvLevel, rstPinLevel, tapResetSel,
                     tapExtest, tapUpdate, tapShift, tapCapture, tdi, tck};

  bsc_sync #(
    .W (SY_W)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .sy    (syIf.syncer)
  );

  logic             ext;
  logic             rsel;
  logic             edgeT;
  logic [NPINS-1:0] pullCalc;
  logic [NPINS-1:0] oeCalc;
  logic [2:0]       clkEnEff;
  logic [2:0]       clkObs;
  logic [2:0]       acEff;
  logic             acObs;
  logic [ADC_W-1:0] adcEff;
  logic [CW-1:0]    capVec;
  logic             statClr;

  always_comb begin
    ext      = syIf.lvl[SY_EXT];
    rsel     = syIf.lvl[SY_RSEL];
    edgeT    = syIf.tckRise;
    pullCalc = ~{NPINS{state_reg.global_pullup_disable}} & ~dirReg & portReg;
    oeCalc   = dirReg;
    capVec   = '0;
    for (int k = 0; k < NPINS; k++) begin
      // Scanned values replace the normal pin controls under external test
      if (ext) begin
        pullCalc[k] = state_reg.up[PIN_W*k + CELL_PU];
        oeCalc[k]   = state_reg.up[PIN_W*k + CELL_OC];
      end
      capVec[PIN_W*k + CELL_PU] = pullCalc[k];
      capVec[PIN_W*k + CELL_OC] = oeCalc[k];
      // Raw pad level, captured with no synchroniser
      capVec[PIN_W*k + CELL_OD] = padIn[k];
    end
    clkEnEff = ext ? state_reg.up[B+M_CLKEN +: 3] : coreClkEn;
    // No cell for the internal RC oscillator: it has no pins
    clkObs   = (clkEnEff & syIf.lvl[SY_CLK +: 3]) | (~clkEnEff & CLK_UNUSED);
    acEff    = ext ? {state_reg.up[B+M_COMPARATOR_BANDGAP_ENABLE], state_reg.up[B+M_ACMUX], state_reg.up[B+M_ACIDLE]} : coreAcCtl;
    acObs    = ~acEff[COMPARATOR_IDLE_BIT] & syIf.lvl[SY_ACO];
    adcEff   = ext ? state_reg.up[B+M_ADC +: ADC_W] : coreAdcCtl;
    capVec[B+M_RSTN]        = syIf.lvl[SY_RSTN];
    capVec[B+M_HIGHVOLT_RESET_OBSERVE]       = syIf.lvl[SY_HIGHVOLT_RESET_OBSERVE];
    capVec[B+M_CLKEN +: 3]  = clkEnEff;
    capVec[B+M_CLKOBS +: 3] = clkObs;
    capVec[B+M_ACIDLE]      = acEff[COMPARATOR_IDLE_BIT];
    capVec[B+M_ACO]         = acObs;
    capVec[B+M_ACMUX]       = acEff[1];
    capVec[B+M_COMPARATOR_BANDGAP_ENABLE]        = acEff[2];
    capVec[B+M_COMP]        = syIf.lvl[SY_COMP];
    capVec[B+M_ADC +: ADC_W] = adcEff;
  end

  always_comb begin
    statClr    = regWr & (regAddr == REG_STAT) & ~regWdata[STAT_FLAG];
    state_next = state_reg;
    // Chain and reset register advance on test clock rising edges
    if (edgeT) begin
      if (rsel) begin
        if (syIf.lvl[SY_SHIFT]) begin
          state_next.rr = syIf.lvl[SY_TDI];
        end
      end else if (syIf.lvl[SY_CAP]) begin
        state_next.sh = capVec;
      end else if (syIf.lvl[SY_SHIFT]) begin
        state_next.sh = {syIf.lvl[SY_TDI], state_reg.sh[CW-1:1]};
      end else if (syIf.lvl[SY_UPD]) begin
        state_next.up = state_reg.sh;
      end
    end
    state_next.tdo     = rsel ? state_next.rr : state_next.sh[0];
    // Reset is forced while the reset register is selected and holds a one
    state_next.coreRst = rsel & state_reg.rr;
    // Set wins over a clearing write
    state_next.flag    = state_reg.coreRst | (state_reg.flag & ~statClr);
    if (regWr && regAddr == REG_CTRL) begin
      state_next.global_pullup_disable = regWdata[CTRL_PUD];
    end
    for (int k = 0; k < NPINS; k++) begin
      if (ext) begin
        state_next.padOut[k] = state_reg.up[PIN_W*k + CELL_OD];
      end else begin
        state_next.padOut[k] = altEn[k] ? altOut[k] : portReg[k];
      end
    end
    state_next.padOe_n = ~oeCalc;
    state_next.pull    = pullCalc;
    state_next.oscEn   = clkEnEff;
    state_next.acCtl   = acEff;
    state_next.adcCtl  = adcEff;
    // Warm-up count after the converter is powered on
    if (!adcEff[ADC_EN_BIT]) begin
      state_next.warm = '0;
    end else if (state_reg.warm != 4'(ADC_WARM_CYC)) begin
      state_next.warm = state_reg.warm + 4'h1;
    end
    state_next.adcReady = adcEff[ADC_EN_BIT] & (state_next.warm == 4'(ADC_WARM_CYC));
    state_next.rdata = 8'h00;
    if (regRd) begin
      case (regAddr)
        REG_CTRL: state_next.rdata = {7'h00, state_reg.global_pullup_disable};
        REG_STAT: state_next.rdata = {4'h0, rsel, ext, state_reg.adcReady, state_reg.flag};
        default:  state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg          <= '0;
      state_reg.up       <= UP_RST;
      state_reg.padOe_n  <= {NPINS{1'b1}};
      state_reg.acCtl    <= 3'h1;
      state_reg.adcCtl   <= ADC_REC;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tdo       = state_reg.tdo;
  assign regRdata  = state_reg.rdata;
  assign padOut    = state_reg.padOut;
  assign padOe_n   = state_reg.padOe_n;
  assign pinPullup = state_reg.pull;
  assign coreReset = state_reg.coreRst;
  assign oscEnable = state_reg.oscEn;
  assign acCtl     = state_reg.acCtl;
  assign adcCtl    = state_reg.adcCtl;
  assign adcReady  = state_reg.adcReady;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  flag_set_a: assert property (coreReset |=> state_reg.flag)
    else $error("test reset flag not set");
  flag_clear_a: assert property (statClr && !coreReset |=> !state_reg.flag)
    else $error("test reset flag not cleared");
  reset_req_a: assert property (rsel && state_reg.rr && $stable(rsel) |=> coreReset)
    else $error("forced reset missing");
  pullup_calc_a: assert property (!ext |=> pinPullup ==
                                  ($past(portReg & ~dirReg) & ~{NPINS{$past(state_reg.global_pullup_disable)}}))
    else $error("pull-up enable wrong");
  drive_map_a: assert property (!ext && !altEn[0] |=> padOut[0] == $past(portReg[0]))
    else $error("pin output not from port register");
  oe_map_a: assert property (!ext |=> padOe_n == ~$past(dirReg))
    else $error("pin enable not from direction");
  clk_unused_a: assert property (!clkEnEff[0] |-> !clkObs[0] && (clkEnEff[2] || clkObs[2]))
    else $error("unused clock cell value wrong");
  comp_idle_a: assert property (acEff[COMPARATOR_IDLE_BIT] |-> !acObs)
    else $error("idle comparator not zero");
  adc_warm_a: assert property ($rose(adcEff[ADC_EN_BIT]) |=> !adcReady [*8])
    else $error("converter ready too early");
  lsb_first_a: assert property (edgeT && !rsel && !syIf.lvl[SY_CAP] && syIf.lvl[SY_SHIFT]
                                |=> tdo == $past(state_reg.sh[1]))
    else $error("chain not shifted toward bit zero");

  // Scanned values reach pins and analog side under external test
  scan_drive_a: assert property (ext |=> padOut[0] == $past(state_reg.up[CELL_OD]))
    else $error("scanned pin data not driven");
  scan_enable_a: assert property (ext |=> padOe_n[0] == !$past(state_reg.up[CELL_OC]))
    else $error("scanned pin control not applied");
  scan_pullup_a: assert property (ext |=> pinPullup[0] == $past(state_reg.up[CELL_PU]))
    else $error("scanned pull-up not applied");
  alt_drive_a: assert property (!ext && altEn[0] |=> padOut[0] == $past(altOut[0]))
    else $error("alternate function not on pin");
  osc_scan_a: assert property (ext |=> oscEnable == $past(state_reg.up[B+M_CLKEN +: 3]))
    else $error("scanned oscillator enable not applied");
  osc_core_a: assert property (!ext |=> oscEnable == $past(coreClkEn))
    else $error("core oscillator enable not passed");
  comp_scan_a: assert property (ext |=> acCtl[0] == $past(state_reg.up[B+M_ACIDLE]))
    else $error("scanned comparator idle not applied");
  adc_scan_a: assert property (ext |=> adcCtl == $past(state_reg.up[B+M_ADC +: ADC_W]))
    else $error("scanned converter controls not applied");
  adc_core_a: assert property (!ext |=> adcCtl == $past(coreAdcCtl))
    else $error("core converter controls not passed");

  // Capture and serial cells
  pad_capture_a: assert property (edgeT && !rsel && syIf.lvl[SY_CAP]
                                  |=> state_reg.sh[CELL_OD] == $past(padIn[0]))
    else $error("pad level not captured");
  rst_capture_a: assert property (edgeT && !rsel && syIf.lvl[SY_CAP]
                                  |=> state_reg.sh[B+M_HIGHVOLT_RESET_OBSERVE -: 2] == $past(syIf.lvl[SY_HIGHVOLT_RESET_OBSERVE -: 2]))
    else $error("reset pin levels not captured");
  clk_xtal_a: assert property (!clkEnEff[1] |-> clkObs[1])
    else $error("unused crystal clock cell not one");
  clk_lowfreq_a: assert property (!clkEnEff[2] |-> clkObs[2])
    else $error("unused low-frequency clock cell not one");
  reset_bit_a: assert property (edgeT && rsel && syIf.lvl[SY_SHIFT] |=> tdo == $past(syIf.lvl[SY_TDI]))
    else $error("reset register bit not shifted");
  reset_release_a: assert property (!rsel |=> !coreReset)
    else $error("forced reset outside reset mode");
  warm_clear_a: assert property (!adcEff[ADC_EN_BIT] |=> !adcReady)
    else $error("converter ready while powered off");
  rdata_idle_a: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data not zero outside a read");
endmodule

// file: tb/bsc_tester.sv
// Tester model that drives the test port and the test clock
`timescale 1ns/10ps
module bsc_tester (
  // Test port levels and clock
  output logic      tck,
  output logic      tdi,
  output logic      tapCapture,
  output logic      tapShift,
  output logic      tapUpdate,
  output logic      tapExtest,
  output logic      tapResetSel,
  // Serial return
  input  wire logic tdo
);
  initial begin
    {tck, tdi, tapCapture, tapShift, tapUpdate, tapExtest, tapResetSel} = '0;
  end

  // One test clock period; levels settle half a period before the rise
  task automatic pulse();
    #80 tck = 1'b1;
    #80 tck = 1'b0;
  endtask

  // Full frame, least significant bit first in and out
  task automatic scan(input logic cap, input logic e, input logic [65:0] din, output logic [65:0] dout);
    dout = '0;
    #7 tapExtest = e;
    if (cap) begin
      tapCapture = 1'b1;
      pulse();
      tapCapture = 1'b0;
    end
    tapShift = 1'b1;
    for (int i = 0; i < 66; i++) begin
      tdi = din[i];
      #80 dout[i] = tdo;
      tck = 1'b1;
      #80 tck = 1'b0;
    end
    tapShift = 1'b0;
    // Released data line does not keep its last value
    tdi = ~tdi;
    tapUpdate = 1'b1;
    pulse();
    tapUpdate = 1'b0;
  endtask

  // One bit into the reset register; a zero also leaves that mode
  task automatic rbit(input logic b);
    #7 tapResetSel = 1'b1;
    tapShift = 1'b1;
    tdi = b;
    pulse();
    tapShift = 1'b0;
    if (!b) tapResetSel = 1'b0;
    tdi = ~tdi;
  endtask
endmodule

// file: tb/tb.sv
// Self-checking testbench for the boundary-scan cell block
`timescale 1ns/10ps
module tb;
  import bsc_pkg::*;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             tck, tdi, cap, sh, upd, ext, rsel, tdo;
  logic [3:0]       regAddr = 4'h0;
  logic [7:0]       regWdata = 8'h00;
  logic             regWr = 1'b0;
  logic             regRd = 1'b0;
  logic [7:0]       regRdata, padOut, padOe_n, pinPullup, d;
  logic [7:0]       portReg = 8'hA5;
  logic [7:0]       dirReg = 8'h0F;
  logic [7:0]       padIn = 8'h3C;
  logic [7:0]       altEn = 8'h00;
  logic [7:0]       altOut = 8'h00;
  logic [2:0]       coreClkEn = 3'h1;
  logic             rstPin = 1'b0;
  logic             highvolt_reset_observe = 1'b1;
  logic [2:0]       clkLine = 3'h1;
  logic             acOut = 1'b1;
  logic             coreReset, adcReady, compIn;
  logic [2:0]       oscEnable, acCtl;
  logic [ADC_W-1:0] adcCtl;
  logic [65:0]      o, v;
  int               miscompares = 0;
  int               n_compared = 0;
  int               cyc = 0;

  always #10 clk = ~clk;
  // Analog input sits between the two window limits
  assign compIn = adcCtl[9:0] > 10'h130;

  bsc_tester bsc_tester_i (.tck(tck), .tdi(tdi), .tapCapture(cap), .tapShift(sh), .tapUpdate(upd),
    .tapExtest(ext), .tapResetSel(rsel), .tdo(tdo));

  bsc_cells bsc_cells_i (.clk(clk), .rst_n(rst_n), .tck(tck), .tdi(tdi), .tapCapture(cap),
    .tapShift(sh), .tapUpdate(upd), .tapExtest(ext), .tapResetSel(rsel), .tdo(tdo),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .portReg(portReg), .dirReg(dirReg), .altEn(altEn), .altOut(altOut), .padIn(padIn),
    .padOut(padOut), .padOe_n(padOe_n), .pinPullup(pinPullup), .rstPinLevel(rstPin),
    .rstHvLevel(highvolt_reset_observe), .coreReset(coreReset), .coreClkEn(coreClkEn), .clkLine(clkLine),
    .oscEnable(oscEnable), .coreAcCtl(3'h1), .acOutIn(acOut), .acCtl(acCtl),
    .coreAdcCtl(29'h2801E00), .compIn(compIn), .adcCtl(adcCtl), .adcReady(adcReady));

  task automatic chk(input string n, input logic [65:0] g, input logic [65:0] e);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge clk);
    regAddr <= a;
    regWdata <= w;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] r);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 r = regRdata;
  endtask

  // Captured pin cells against core levels and raw pads
  task automatic chkPins(input logic global_pullup_disable);
    for (int k = 0; k < 8; k++) begin
      chk("pullup", 66'(o[3*k]), 66'(~global_pullup_disable & ~dirReg[k] & portReg[k]));
      chk("control", 66'(o[3*k+1]), 66'(dirReg[k]));
      chk("data", 66'(o[3*k+2]), 66'(padIn[k]));
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    #1 chk("padOe_n", 66'(padOe_n), 66'hFF);
    chk("acCtl", 66'(acCtl), 66'h1);
    chk("adcCtl", 66'(adcCtl), 66'h2801E00);
    chk("oscEnable", 66'(oscEnable), 66'h0);
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    // Capture with pull-up allowed, then disabled
    wr(REG_CTRL, 8'h00);
    bsc_tester_i.scan(1'b1, 1'b0, '0, o);
    chkPins(1'b0);
    chk("resetObs", 66'(o[25:24]), 66'h2);
    chk("clkObs", 66'(o[31:29]), 66'h7);
    chk("padOut", 66'(padOut), 66'hA5);
    chk("oscEnable", 66'(oscEnable), 66'h1);
    chk("acOut", 66'(o[33]), 66'h0);
    padIn = 8'hC3;
    wr(REG_CTRL, 8'h01);
    rd(REG_CTRL, d);
    chk("ctrl", 66'(d), 66'h01);
    bsc_tester_i.scan(1'b1, 1'b0, '0, o);
    chkPins(1'b1);
    // Alternate function drives the pin outside external test
    @(posedge clk);
    altEn <= 8'h0F;
    altOut <= 8'h0A;
    repeat (2) @(posedge clk);
    #1 chk("padOutAlt", 66'(padOut), 66'hAA);
    // Pattern comes back whole after exactly the chain length
    v = 66'h2_9C3A_5F01_7E46_B8D5;
    bsc_tester_i.scan(1'b0, 1'b0, v, o);
    bsc_tester_i.scan(1'b0, 1'b0, '0, o);
    chk("chain", o, v);
    // Drive pins and analog side, crystal only, channel 3 input
    v = {29'h6808D23, 8'h00, 3'b010, 2'b00, 24'h000056};
    bsc_tester_i.scan(1'b1, 1'b1, v, o);
    for (int i = 0; i < 20 && adcCtl[ADC_EN_BIT] !== 1'b1; i++) @(posedge clk);
    #1;
    chk("padOut", 66'(padOut), 66'h01);
    chk("padOe_n", 66'(padOe_n), 66'hFC);
    chk("pinPullup", 66'(pinPullup), 66'h04);
    chk("oscEnable", 66'(oscEnable), 66'h2);
    chk("acCtl", 66'(acCtl), 66'h0);
    chk("adcCtl", 66'(adcCtl), 66'h6808D23);
    repeat (4) @(posedge clk);
    chk("adcReady", 66'(adcReady), 66'h0);
    repeat (7) @(posedge clk);
    chk("adcReady", 66'(adcReady), 66'h1);
    rd(REG_STAT, d);
    chk("stat", 66'(d), 66'h06);
    // Window: lower limit reads low, upper limit reads high
    v[46:37] = 10'h143;
    bsc_tester_i.scan(1'b1, 1'b1, v, o);
    chk("compLow", 66'(o[36]), 66'h0);
    chk("clkObsExt", 66'(o[31:29]), 66'h4);
    chk("acOutActive", 66'(o[33]), 66'h1);
    v[46:37] = 10'h123;
    bsc_tester_i.scan(1'b1, 1'b1, v, o);
    chk("compHigh", 66'(o[36]), 66'h1);
    bsc_tester_i.scan(1'b0, 1'b0, '0, o);
    // Forced reset through the reset register
    bsc_tester_i.rbit(1'b1);
    for (int i = 0; i < 20 && coreReset !== 1'b1; i++) @(posedge clk);
    chk("coreReset", 66'(coreReset), 66'h1);
    rd(REG_STAT, d);
    chk("flag", 66'(d & 8'h09), 66'h09);
    // Clearing write loses against a reset still forced
    wr(REG_STAT, 8'h00);
    rd(REG_STAT, d);
    chk("flagHeld", 66'(d[0]), 66'h1);
    bsc_tester_i.rbit(1'b0);
    repeat (8) @(posedge clk);
    chk("coreReset", 66'(coreReset), 66'h0);
    wr(REG_STAT, 8'h01);
    rd(REG_STAT, d);
    chk("flag", 66'(d[0]), 66'h1);
    wr(REG_STAT, 8'h00);
    rd(REG_STAT, d);
    chk("flag", 66'(d[0]), 66'h0);
    // Flag set again, then cleared by a reset in mid-run
    bsc_tester_i.rbit(1'b1);
    bsc_tester_i.rbit(1'b0);
    rd(REG_STAT, d);
    chk("flagAgain", 66'(d[0]), 66'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(REG_STAT, d);
    chk("flagPor", 66'(d[0]), 66'h0);
    rd(4'hF, d);
    chk("unmapped", 66'(d), 66'h00);
    report_and_stop();
  end
endmodule
